// File: src/dmacr_pkg.sv
// Package: offsets, field layout and reset values of the DMA control registers
package dmacr_pkg;

	// ======================================================================
	// Register byte offsets
	localparam logic [11:0] OFF_STATE     = 12'h000;
	localparam logic [11:0] OFF_CONFIG    = 12'h004;
	localparam logic [11:0] OFF_PRIMARY   = 12'h008;
	localparam logic [11:0] OFF_ALTERNATE = 12'h00c;
	localparam logic [11:0] OFF_SOFT_REQ  = 12'h014;
	localparam logic [11:0] OFF_MASK_SET  = 12'h020;
	localparam logic [11:0] OFF_MASK_CLR  = 12'h024;
	localparam logic [11:0] OFF_CHEN_SET  = 12'h028;
	localparam logic [11:0] OFF_CHEN_CLR  = 12'h02c;

	// ======================================================================
	// Field layout and fixed values
	localparam int          CHANNELS      = 32;
	localparam int          PTR_LSB       = 10;
	localparam int          PTR_W         = 32 - PTR_LSB;
	localparam int          ENABLE_BIT    = 0;
	localparam logic [31:0] STATE_FIXED   = 32'h101f_0000;
	localparam logic [3:0]  STATE_UNDEF   = 4'h0;
	localparam logic [31:0] ALT_OFFSET    = 32'h0000_0200;

	// ======================================================================
	// Values after reset
	localparam logic        RST_ENABLE    = 1'b0;
	localparam logic [31:0] RST_WORD      = 32'h0000_0000;

endpackage : dmacr_pkg

// File: src/dmacr_bits_if.sv
// Interface: strobes and state of one set/clear channel bit bank
`timescale 1ns/1ps
`default_nettype none

interface dmacr_bits_if;
	logic        set_stb;
	logic        clr_stb;
	logic [31:0] wdata;
	logic [31:0] bits;

	modport owner (input set_stb, input clr_stb, input wdata, output bits);
	modport ctrl  (output set_stb, output clr_stb, output wdata, input bits);
endinterface : dmacr_bits_if

`default_nettype wire

// File: src/dmacr_setclr.sv
// Module: 32-bit channel bank written through separate set and clear words
`timescale 1ns/1ps
`default_nettype none

module dmacr_setclr (
	input  wire logic   clk,
	input  wire logic   rst_n,
	dmacr_bits_if.owner bank
);

	typedef struct packed {
		logic [31:0] bits;
	} dmacr_sc_state_t;

	dmacr_sc_state_t state_reg;
	dmacr_sc_state_t state_next;

	// ======================================================================
	// Ones in the set word raise bits, ones in the clear word drop them
	always_comb begin
		state_next = state_reg;
		if (bank.set_stb) begin
			state_next.bits = state_reg.bits | bank.wdata;
		end
		if (bank.clr_stb) begin
			state_next.bits = state_next.bits & ~bank.wdata;
		end
	end

	// Zeros in either word leave the channel alone
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_reg <= '{bits: dmacr_pkg::RST_WORD};
		end else begin
			state_reg <= state_next;
		end
	end

	assign bank.bits = state_reg.bits;

	// ======================================================================
	// Checks
	a_clear_bits_drop: assert property (
		@(posedge clk) disable iff (!rst_n)
		bank.clr_stb && !bank.set_stb |=>
			((bank.bits & $past(bank.wdata)) == 32'h0000_0000) &&
			((bank.bits | $past(bank.wdata)) ==
			 ($past(bank.bits) | $past(bank.wdata))))
		else $error("clear word did not drop exactly its channels");

	a_set_bits_raise: assert property (
		@(posedge clk) disable iff (!rst_n)
		bank.set_stb && !bank.clr_stb |=>
			bank.bits == ($past(bank.bits) | $past(bank.wdata)))
		else $error("set word did not raise its channels");

endmodule : dmacr_setclr

`default_nettype wire

// File: src/dmacr_regs.sv
// Module: global control and table pointer registers of the DMA engine
`timescale 1ns/1ps
`default_nettype none

module dmacr_regs (
	input  wire logic        clk,
	input  wire logic        rst_n,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Towards the channel engine
	output logic             engine_enable,
	output logic      [31:0] primary_table_pointer,
	output logic      [31:0] alternate_table_pointer,
	output logic      [31:0] channel_soft_trigger,
	output logic      [31:0] request_mask,
	output logic      [31:0] channel_enable
);

	typedef struct packed {
		logic                         enable;
		logic [dmacr_pkg::PTR_W-1:0] base;
		logic [31:0]                  alt;
		logic [31:0]                  trig;
		logic [31:0]                  rdata;
		logic                         err;
	} dmacr_state_t;

	dmacr_state_t state_reg;
	dmacr_state_t state_next;

	dmacr_bits_if mask_bank ();
	dmacr_bits_if chen_bank ();

	logic        setup;
	logic        wr;
	logic        hit;
	logic [31:0] rd_mux;

	// ======================================================================
	// Bus decode
	assign setup = psel && !penable;
	assign wr    = psel && penable && pwrite;

	// Read data and decode are sampled in setup so prdata is a flop
	always_comb begin
		hit    = 1'b1;
		rd_mux = 32'h0000_0000;
		case (paddr)
			dmacr_pkg::OFF_STATE: begin
				rd_mux = dmacr_pkg::STATE_FIXED;
				rd_mux[7:4] = dmacr_pkg::STATE_UNDEF;
				rd_mux[dmacr_pkg::ENABLE_BIT] = state_reg.enable;
			end
			dmacr_pkg::OFF_PRIMARY: begin
				rd_mux = {state_reg.base, 10'h000};
			end
			dmacr_pkg::OFF_ALTERNATE: begin
				rd_mux = state_reg.alt;
			end
			// Write-only words read back as zero
			dmacr_pkg::OFF_CONFIG,
			dmacr_pkg::OFF_SOFT_REQ,
			dmacr_pkg::OFF_MASK_SET,
			dmacr_pkg::OFF_MASK_CLR,
			dmacr_pkg::OFF_CHEN_SET,
			dmacr_pkg::OFF_CHEN_CLR: begin
				rd_mux = 32'h0000_0000;
			end
			default: begin
				hit = 1'b0;
			end
		endcase
	end

	// ======================================================================
	// Register updates
	always_comb begin
		state_next      = state_reg;
		state_next.trig = 32'h0000_0000; // Requests are one-cycle pulses
		if (setup) begin
			state_next.rdata = rd_mux;
			state_next.err   = !hit;
		end
		if (wr) begin
			case (paddr)
				dmacr_pkg::OFF_CONFIG: begin
					state_next.enable = pwdata[dmacr_pkg::ENABLE_BIT];
				end
				dmacr_pkg::OFF_PRIMARY: begin
					state_next.base = pwdata[31:dmacr_pkg::PTR_LSB];
					// Kept in a flop so the read path has no adder
					state_next.alt = {pwdata[31:dmacr_pkg::PTR_LSB], 10'h000}
						+ dmacr_pkg::ALT_OFFSET;
				end
				dmacr_pkg::OFF_SOFT_REQ: begin
					state_next.trig = pwdata;
				end
				default: begin
					state_next.trig = 32'h0000_0000;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_reg <= '{enable: dmacr_pkg::RST_ENABLE,
				base: dmacr_pkg::RST_WORD[31:dmacr_pkg::PTR_LSB],
				alt: dmacr_pkg::RST_WORD,
				trig: dmacr_pkg::RST_WORD,
				rdata: dmacr_pkg::RST_WORD,
				err: 1'b0};
		end else begin
			state_reg <= state_next;
		end
	end

	// ======================================================================
	// Mask and channel enable banks; bring-up writes all ones to the sets
	assign mask_bank.set_stb = wr && (paddr == dmacr_pkg::OFF_MASK_SET);
	assign mask_bank.clr_stb = wr && (paddr == dmacr_pkg::OFF_MASK_CLR);
	assign mask_bank.wdata   = pwdata;
	assign chen_bank.set_stb = wr && (paddr == dmacr_pkg::OFF_CHEN_SET);
	assign chen_bank.clr_stb = wr && (paddr == dmacr_pkg::OFF_CHEN_CLR);
	assign chen_bank.wdata   = pwdata;

	dmacr_setclr u_mask (
		.clk   (clk),
		.rst_n (rst_n),
		.bank  (mask_bank)
	);

	dmacr_setclr u_chen (
		.clk   (clk),
		.rst_n (rst_n),
		.bank  (chen_bank)
	);

	// ======================================================================
	// Outputs
	assign prdata                  = state_reg.rdata;
	assign pready                  = 1'b1;
	assign pslverr                 = psel && penable && state_reg.err;
	assign engine_enable           = state_reg.enable;
	assign primary_table_pointer   = {state_reg.base, 10'h000};
	assign alternate_table_pointer = state_reg.alt;
	assign channel_soft_trigger    = state_reg.trig;
	assign request_mask            = mask_bank.bits;
	assign channel_enable          = chen_bank.bits;

	// ======================================================================
	// Checks
	a_state_fixed_bits: assert property (
		@(posedge clk) disable iff (!rst_n)
		psel && penable && !pwrite && paddr == dmacr_pkg::OFF_STATE |->
			prdata[31:1] == 31'h080f_8000)
		else $error("state word fixed bits wrong");

	a_state_enable_bit: assert property (
		@(posedge clk) disable iff (!rst_n)
		psel && penable && !pwrite && paddr == dmacr_pkg::OFF_STATE
			&& $past(setup) |-> prdata[0] == engine_enable)
		else $error("state word bit 0 differs from engine enable");

	a_config_sets_enable: assert property (
		@(posedge clk) disable iff (!rst_n)
		wr && paddr == dmacr_pkg::OFF_CONFIG |=>
			engine_enable == $past(pwdata[0]))
		else $error("config write did not set engine enable");

	a_primary_low_zero: assert property (
		@(posedge clk) disable iff (!rst_n)
		primary_table_pointer[9:0] == 10'h000)
		else $error("primary pointer low bits not zero");

	a_primary_write: assert property (
		@(posedge clk) disable iff (!rst_n)
		wr && paddr == dmacr_pkg::OFF_PRIMARY |=>
			primary_table_pointer[31:10] == $past(pwdata[31:10]))
		else $error("primary pointer not stored");

	a_alt_follows_primary: assert property (
		@(posedge clk) disable iff (!rst_n)
		wr && paddr == dmacr_pkg::OFF_PRIMARY |=>
			alternate_table_pointer == primary_table_pointer + 32'h0000_0200)
		else $error("alternate pointer does not follow primary");

	a_alt_reset_zero: assert property (
		@(posedge clk)
		!rst_n |=> alternate_table_pointer == 32'h0000_0000)
		else $error("alternate pointer not zero after reset");

	a_trigger_pulse: assert property (
		@(posedge clk) disable iff (!rst_n)
		wr && paddr == dmacr_pkg::OFF_SOFT_REQ |=>
			channel_soft_trigger == $past(pwdata) ##1
			(channel_soft_trigger == 32'h0000_0000 || $past(wr)))
		else $error("soft request pulse wrong");

	a_trigger_idle: assert property (
		@(posedge clk) disable iff (!rst_n)
		!(wr && paddr == dmacr_pkg::OFF_SOFT_REQ) |=>
			channel_soft_trigger == 32'h0000_0000)
		else $error("soft request raised without a write");

endmodule : dmacr_regs

`default_nettype wire

// File: tb/dmacr_tb.sv
// Testbench: self-checking scenarios for the DMA control registers
`timescale 1ns/1ps
`default_nettype none

module testbench;
	// ======================================================================
	// Ports, counters
	logic        clk;
	logic        rst_n;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        en;
	logic [31:0] pri;
	logic [31:0] alt;
	logic [31:0] trig;
	logic [31:0] mask;
	logic [31:0] chen;
	logic [31:0] rdat;
	logic        rerr;
	int          err_total;
	int          checks_done;
	int          cycles;

	// 8 ns period
	always #4 clk = ~clk;

	dmacr_regs i_dmacr_regs (.clk(clk), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.engine_enable(en), .primary_table_pointer(pri),
		.alternate_table_pointer(alt), .channel_soft_trigger(trig),
		.request_mask(mask), .channel_enable(chen));

	// ======================================================================
	// Shared tasks
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// One APB transfer; request held until pready is seen high
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		@(negedge clk);
		psel = 1'b1;
		pwrite = wr;
		paddr = a;
		pwdata = d;
		@(negedge clk);
		penable = 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		@(negedge clk);
		psel = 1'b0;
		penable = 1'b0;
	endtask

	// ======================================================================
	// Scenarios
	task automatic t_reset();
		repeat (3) @(posedge clk);
		@(negedge clk);
		chk("pready", {31'h0, pready}, 32'h1);
		rst_n = 1'b1;
		chk("pri", pri, 32'h0);
		chk("alt", alt, 32'h0);
		apb(1'b0, dmacr_pkg::OFF_STATE, 32'h0);
		chk("state", rdat & 32'hffff_ff0f, 32'h101f_0000);
		chk("err", {31'h0, rerr}, 32'h0);
		apb(1'b0, dmacr_pkg::OFF_ALTERNATE, 32'h0);
		chk("alt rd", rdat, 32'h0);
		$display("t_reset done");
	endtask

	// Config written both ways; state bit 0 follows, writes to state ignored
	task automatic t_enable();
		for (int v = 1; v >= 0; v--) begin
			apb(1'b1, dmacr_pkg::OFF_CONFIG, 32'(v));
			chk("en", {31'h0, en}, 32'(v));
			apb(1'b1, dmacr_pkg::OFF_STATE, 32'h0000_0001 - 32'(v));
			apb(1'b0, dmacr_pkg::OFF_STATE, 32'h0);
			chk("state", rdat & 32'hffff_ff0f, 32'h101f_0000 | v);
			apb(1'b0, dmacr_pkg::OFF_CONFIG, 32'h0);
			chk("cfg rd", rdat, 32'h0);
		end
		$display("t_enable done");
	endtask

	// Pointer aligns, alternate follows, reset mid-run clears both
	task automatic t_pointer();
		logic [31:0] v [2];
		v[0] = 32'hffff_ffff;
		v[1] = 32'h1234_5678;
		foreach (v[i]) begin
			apb(1'b1, dmacr_pkg::OFF_PRIMARY, v[i]);
			apb(1'b1, dmacr_pkg::OFF_ALTERNATE, 32'h0);
			apb(1'b0, dmacr_pkg::OFF_PRIMARY, 32'h0);
			chk("pri rd", rdat, v[i] & 32'hffff_fc00);
			apb(1'b0, dmacr_pkg::OFF_ALTERNATE, 32'h0);
			chk("alt rd", rdat, (v[i] & 32'hffff_fc00) + 32'h200);
			chk("alt", alt, (v[i] & 32'hffff_fc00) + 32'h200);
		end
		// Leave live state behind so the reset has something to clear
		apb(1'b1, dmacr_pkg::OFF_CONFIG, 32'h0000_0001);
		apb(1'b1, dmacr_pkg::OFF_MASK_SET, 32'h0000_00ff);
		@(negedge clk);
		rst_n = 1'b0;
		@(negedge clk);
		rst_n = 1'b1;
		chk("en rst", {31'h0, en}, 32'h0);
		chk("mask rst", mask, 32'h0);
		chk("pri rst", pri, 32'h0);
		chk("alt rst", alt, 32'h0);
		$display("t_pointer done");
	endtask

	// Soft request pulses one cycle on exactly the written channels
	task automatic t_trigger();
		apb(1'b1, dmacr_pkg::OFF_SOFT_REQ, 32'ha5a5_0001);
		chk("trig", trig, 32'ha5a5_0001);
		@(negedge clk);
		chk("trig end", trig, 32'h0);
		apb(1'b1, dmacr_pkg::OFF_SOFT_REQ, 32'h0);
		chk("trig zero", trig, 32'h0);
		$display("t_trigger done");
	endtask

	// Bring-up order, then unmask only the channels in use
	task automatic t_bringup();
		apb(1'b1, dmacr_pkg::OFF_CONFIG, 32'h0000_0001);
		apb(1'b1, dmacr_pkg::OFF_MASK_SET, 32'hffff_ffff);
		apb(1'b1, dmacr_pkg::OFF_CHEN_SET, 32'hffff_ffff);
		chk("mask", mask, 32'hffff_ffff);
		chk("chen", chen, 32'hffff_ffff);
		apb(1'b1, dmacr_pkg::OFF_MASK_CLR, 32'h8000_0003);
		chk("unmask", mask, 32'h7fff_fffc);
		chk("chen kept", chen, 32'hffff_ffff);
		// Channel enable clear drops only its own bits
		apb(1'b1, dmacr_pkg::OFF_CHEN_CLR, 32'h0000_00f0);
		chk("chen clr", chen, 32'hffff_ff0f);
		chk("mask kept", mask, 32'h7fff_fffc);
		$display("t_bringup done");
	endtask

	// Unmapped offsets are refused and change nothing
	task automatic t_unmapped();
		apb(1'b0, 12'h010, 32'h0);
		chk("err", {31'h0, rerr}, 32'h1);
		chk("data", rdat, 32'h0);
		apb(1'b1, 12'h018, 32'hffff_ffff);
		chk("err", {31'h0, rerr}, 32'h1);
		chk("mask", mask, 32'h7fff_fffc);
		chk("en", {31'h0, en}, 32'h1);
		$display("t_unmapped done");
	endtask

	// Cycle ceiling far above the sequence length
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			err_total++;
			print_verdict();
		end
	end

	// Main sequence
	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		err_total = 0;
		checks_done = 0;
		cycles = 0;
		t_reset();
		t_enable();
		t_pointer();
		t_trigger();
		t_bringup();
		t_unmapped();
		print_verdict();
	end
endmodule // testbench

`default_nettype wire
